// file: rtl/pnl_pkg.sv
// Shared constants and types of the front-panel status and serial-port configuration block.
package pnl_pkg;

	// Register byte offsets.
	localparam logic [7:0] PNL_OFS_CTRL   = 8'h00;
	localparam logic [7:0] PNL_OFS_CRASH  = 8'h04;
	localparam logic [7:0] PNL_OFS_SWCFG  = 8'h08;
	localparam logic [7:0] PNL_OFS_STATUS = 8'h0c;
	localparam logic [7:0] PNL_OFS_PORT   = 8'h10;
	localparam int         PNL_ADDR_W     = 8;

	// Control register bit positions.
	localparam int PNL_CTRL_DIAG_OK = 0;
	localparam int PNL_CTRL_RUNNING = 1;
	localparam int PNL_CTRL_FATAL   = 2;
	localparam int PNL_CTRL_BRIDGE  = 3;

	// Status register field positions.
	localparam int PNL_ST_PROT_POS = 0;
	localparam int PNL_ST_PORT_POS = 2;
	localparam int PNL_ST_PROTECT  = 4;
	localparam int PNL_ST_ADDR_BAD = 5;
	localparam int PNL_ST_NODE     = 8;
	localparam int PNL_ST_GROUP    = 16;
	localparam int PNL_ST_LAMPS    = 20;

	// Slide switch positions.
	localparam logic [1:0] PNL_POS_TOP = 2'h0;
	localparam logic [1:0] PNL_POS_MID = 2'h1;
	localparam logic [1:0] PNL_POS_BOT = 2'h2;

	// Baud index table: 0=50 1=75 2=110 3=134.5 4=150 5=300 6=600 7=1200 8=1800 9=2000 10=2400
	// 11=3600 12=4800 13=7200 14=9600 15=19200.
	localparam logic [3:0] PNL_BAUD_2400 = 4'ha;
	localparam logic [3:0] PNL_BAUD_9600 = 4'he;
	localparam logic [1:0] PNL_PAR_NONE  = 2'h0;
	localparam logic [1:0] PNL_PAR_ODD   = 2'h1;
	localparam logic [1:0] PNL_PAR_EVEN  = 2'h2;

	// Address limits.
	localparam logic [7:0] PNL_SER_ADDR_MIN  = 8'h01;
	localparam logic [7:0] PNL_SER_ADDR_MAX  = 8'hf7;
	localparam logic [7:0] PNL_NODE_ADDR_MAX = 8'h40;
	localparam logic [3:0] PNL_DIGIT_MAX     = 4'h9;
	localparam logic [7:0] PNL_TENS_WEIGHT   = 8'h0a;

	// Blink timing.
	localparam int unsigned PNL_CLK_KHZ      = 250000;
	localparam int unsigned PNL_BLINK_HALF_MS = 250;
	localparam int unsigned PNL_BLINK_GAP_MS  = 1500;
	localparam int unsigned PNL_BLINK_HALF_CYC = PNL_BLINK_HALF_MS * PNL_CLK_KHZ / 1000;
	localparam int unsigned PNL_BLINK_GAP_CYC  = PNL_BLINK_GAP_MS * PNL_CLK_KHZ / 1000;

	// Blink groups; zero means continuous blinking.
	localparam logic [3:0] PNL_GRP_CONT  = 4'h0;
	localparam logic [3:0] PNL_GRP_OTHER = 4'h1;

	typedef enum logic [1:0] {
		PNL_BL_ON,
		PNL_BL_OFF,
		PNL_BL_GAP
	} pnl_blink_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       two_stop;
		logic       eight_bits;
		logic [1:0] parity;
		logic [3:0] baud;
	} pnl_ser_cfg_t;

	localparam pnl_ser_cfg_t PNL_CFG_RESET = '{addr: 8'h01, two_stop: 1'b0, eight_bits: 1'b1,
		parity: 2'h2, baud: 4'he};

	typedef struct packed {
		logic fault;
		logic battery;
		logic protect;
		logic net;
		logic serial;
		logic run;
		logic ready;
	} pnl_lamps_t;

endpackage

// file: rtl/pnl_top.sv
// Front-panel lamps, switch decoding and serial-port configuration with an AHB-Lite register slave.
`timescale 1ns/1ps
module pnl_top
	import pnl_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYC = PNL_BLINK_HALF_CYC,
	parameter int unsigned BLINK_GAP_CYC  = PNL_BLINK_GAP_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic                  hready,
	input  wire logic [31:0]           hwdata,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	input  wire logic [1:0]            prot_sw_pos,
	input  wire logic [1:0]            port_sw_pos,
	input  wire logic [3:0]            tens_digit_selector,
	input  wire logic [3:0]            ones_digit_selector,
	input  wire logic                  ser_link_active,
	input  wire logic                  net_link_active,
	input  wire logic                  battery_low,
	input  wire logic                  net_comm_error,
	output pnl_lamps_t                 lamps,
	output pnl_ser_cfg_t               port_cfg,
	output logic                       bridge_mode,
	output logic                       mem_protect,
	output logic [7:0]                 node_addr,
	output logic                       node_addr_bad
);

	typedef struct packed {
		logic                  diag_ok;
		logic                  running;
		logic                  fatal;
		logic                  sw_bridge;
		logic [15:0]           crash;
		pnl_ser_cfg_t          sw_cfg;
		pnl_ser_cfg_t          port_cfg;
		logic                  bridge;
		logic                  protect;
		pnl_lamps_t            lamps;
		logic [7:0]            node;
		logic                  node_bad;
		pnl_blink_t            bl;
		logic [31:0]           tmr;
		logic [3:0]            left;
		logic [3:0]            group;
		logic                  wr_pend;
		logic [PNL_ADDR_W-1:0] wr_ofs;
		logic [31:0]           rdata;
		logic                  ready;
	} pnl_state_t;

	pnl_state_t s_q;
	pnl_state_t s_d;

	// Power-up contents: lamps dark, software settings at their defaults and the bus ready at once.
	localparam pnl_state_t S_RESET = '{
		diag_ok:   1'b0,
		running:   1'b0,
		fatal:     1'b0,
		sw_bridge: 1'b0,
		crash:     16'h0,
		sw_cfg:    PNL_CFG_RESET,
		port_cfg:  PNL_CFG_RESET,
		bridge:    1'b0,
		protect:   1'b0,
		lamps:     '0,
		node:      8'h0,
		node_bad:  1'b0,
		bl:        PNL_BL_GAP,
		tmr:       32'h0,
		left:      4'h0,
		group:     PNL_GRP_CONT,
		wr_pend:   1'b0,
		wr_ofs:    '0,
		rdata:     32'h0,
		ready:     1'b1
	};

	// Blink counts of the crash code groups, and the one parity code that selects nothing.
	localparam logic [3:0] GRP_TWO    = 4'h2;
	localparam logic [3:0] GRP_THREE  = 4'h3;
	localparam logic [3:0] GRP_FOUR   = 4'h4;
	localparam logic [3:0] GRP_FIVE   = 4'h5;
	localparam logic [3:0] GRP_SIX    = 4'h6;
	localparam logic [3:0] GRP_SEVEN  = 4'h7;
	localparam logic [3:0] GRP_EIGHT  = 4'h8;
	localparam logic [1:0] PAR_UNUSED = 2'h3;

	// True when a crash code lies inside an inclusive range of codes.
	function automatic logic in_range(input logic [15:0] code, input logic [15:0] lo, input logic [15:0] hi);
		return code >= lo && code <= hi;
	endfunction

	// Maps a crash code onto the number of run lamp blinks.
	function automatic logic [3:0] blink_group(input logic [15:0] code);
		logic [3:0] g;
		g = PNL_GRP_OTHER;
		if (code == 16'h0000) begin
			g = PNL_GRP_CONT;
		end else if (code == 16'h080b || code == 16'h080c || code == 16'h082e) begin
			g = GRP_TWO;
		end else if (code == 16'h0769 || in_range(code, 16'h072a, 16'h0730)) begin
			g = GRP_THREE;
		end else if (in_range(code, 16'h0604, 16'h0631)) begin
			g = GRP_FOUR;
		end else if (code == 16'h0503 || code == 16'h052d) begin
			g = GRP_FIVE;
		end else if (code == 16'h0402) begin
			g = GRP_SIX;
		end else if (code == 16'h0300 || code == 16'h0301) begin
			g = GRP_SEVEN;
		end else if (in_range(code, 16'h8001, 16'h8003)) begin
			g = GRP_EIGHT;
		end
		return g;
	endfunction

	// Decimal value of the two rotary digits.
	function automatic logic [7:0] rotary_value(input logic [3:0] tens, input logic [3:0] ones);
		return 8'({4'h0, tens} * PNL_TENS_WEIGHT + {4'h0, ones});
	endfunction

	// A software configuration is taken only when every field is legal.
	function automatic logic cfg_legal(input pnl_ser_cfg_t c);
		return c.parity != PAR_UNUSED && c.addr >= PNL_SER_ADDR_MIN && c.addr <= PNL_SER_ADDR_MAX;
	endfunction

	// A rotary digit shows zero to nine; the codes above are unused positions.
	function automatic logic digit_ok(input logic [3:0] d);
		return d <= PNL_DIGIT_MAX;
	endfunction

	// Port settings of a fixed switch position; both fixed modes use even parity and one stop bit.
	function automatic pnl_ser_cfg_t fixed_cfg(input logic [3:0] baud, input logic eight_bits,
		input logic [7:0] addr);
		pnl_ser_cfg_t c;
		c.addr       = addr;
		c.two_stop   = 1'b0;
		c.eight_bits = eight_bits;
		c.parity     = PNL_PAR_EVEN;
		c.baud       = baud;
		return c;
	endfunction

	// Last cycle of a blink phase of the given length.
	function automatic logic phase_end(input logic [31:0] tmr, input int unsigned len);
		return tmr == 32'(len - 1);
	endfunction

	// Read data of one offset; the status word gathers switches, decoded state and lamps.
	function automatic logic [31:0] read_mux(input logic [PNL_ADDR_W-1:0] ofs, input pnl_state_t s,
		input logic [1:0] prot_pos, input logic [1:0] port_pos);
		logic [31:0] r;
		r = 32'h0;
		unique case (ofs)
			PNL_OFS_CTRL: begin
				r[PNL_CTRL_DIAG_OK] = s.diag_ok;
				r[PNL_CTRL_RUNNING] = s.running;
				r[PNL_CTRL_FATAL]   = s.fatal;
				r[PNL_CTRL_BRIDGE]  = s.sw_bridge;
			end
			PNL_OFS_CRASH: r[15:0] = s.crash;
			PNL_OFS_SWCFG: r[15:0] = s.sw_cfg;
			PNL_OFS_STATUS: begin
				r[PNL_ST_PROT_POS +: 2] = prot_pos;
				r[PNL_ST_PORT_POS +: 2] = port_pos;
				r[PNL_ST_PROTECT]       = s.protect;
				r[PNL_ST_ADDR_BAD]      = s.node_bad;
				r[PNL_ST_NODE +: 8]     = s.node;
				r[PNL_ST_GROUP +: 4]    = s.group;
				r[PNL_ST_LAMPS +: 7]    = s.lamps;
			end
			PNL_OFS_PORT: r[15:0] = s.port_cfg;
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	always_comb begin
		logic       addr_ok;
		logic       run_lamp;
		logic       half_end;
		logic       gap_end;
		logic [7:0] rot;
		pnl_ser_cfg_t wcfg;
		logic       take;
		addr_ok  = 1'b0;
		take     = 1'b0;
		run_lamp = 1'b0;
		half_end = 1'b0;
		gap_end  = 1'b0;
		rot      = 8'h0;
		wcfg     = PNL_CFG_RESET;
		s_d      = s_q;

		// Data phase of a write accepted in the previous cycle.
		// Write data stands only in the data phase, so the offset is held over from the address phase.
		if (s_q.wr_pend) begin
			s_d.wr_pend = 1'b0;
			unique case (s_q.wr_ofs)
				PNL_OFS_CTRL: begin
					s_d.diag_ok   = hwdata[PNL_CTRL_DIAG_OK];
					s_d.running   = hwdata[PNL_CTRL_RUNNING];
					s_d.fatal     = hwdata[PNL_CTRL_FATAL];
					s_d.sw_bridge = hwdata[PNL_CTRL_BRIDGE];
				end
				PNL_OFS_CRASH: s_d.crash = hwdata[15:0];
				PNL_OFS_SWCFG: begin
					wcfg = pnl_ser_cfg_t'(hwdata[15:0]);
					if (cfg_legal(wcfg)) begin
						s_d.sw_cfg = wcfg;
					end
				end
				default: s_d.wr_pend = 1'b0;
			endcase
		end

		// Rotary address decode.
		rot     = rotary_value(tens_digit_selector, ones_digit_selector);
		// A digit above nine makes the address invalid even where the sum would fall in range.
		addr_ok = digit_ok(tens_digit_selector) && digit_ok(ones_digit_selector)
			&& rot != 8'h0 && rot <= PNL_NODE_ADDR_MAX;
		s_d.node     = rot;
		s_d.node_bad = !addr_ok;

		// Switch decode and effective port settings.
		s_d.protect = prot_sw_pos == PNL_POS_TOP;
		if (port_sw_pos == PNL_POS_TOP) begin
			s_d.port_cfg = fixed_cfg(PNL_BAUD_2400, 1'b0, rot);
			s_d.bridge = 1'b1;
		end else if (port_sw_pos == PNL_POS_MID) begin
			s_d.port_cfg = fixed_cfg(PNL_BAUD_9600, 1'b1, rot);
			s_d.bridge = 1'b1;
		end else begin
			// The unused fourth switch code is treated as the bottom position.
			s_d.port_cfg = s_d.sw_cfg;
			s_d.bridge   = s_d.sw_bridge;
		end

		// Run lamp blink sequencer.
		// The timer is a full word so that the default gap at the rated clock still fits.
		half_end = phase_end(s_q.tmr, BLINK_HALF_CYC);
		gap_end  = phase_end(s_q.tmr, BLINK_GAP_CYC);
		s_d.group = blink_group(s_d.crash);
		if (!s_d.fatal) begin
			// Parked at the end of a gap so the first flash starts on the same edge that sets the fatal bit.
			s_d.bl  = PNL_BL_GAP;
			s_d.tmr = 32'(BLINK_GAP_CYC - 1);
		end else begin
			s_d.tmr = s_q.tmr + 32'h1;
			unique case (s_q.bl)
				PNL_BL_ON: if (half_end) begin
					s_d.bl   = PNL_BL_OFF;
					s_d.tmr  = 32'h0;
					s_d.left = s_q.left - 4'h1;
				end
				PNL_BL_OFF: if (half_end) begin
					s_d.tmr = 32'h0;
					s_d.bl  = (s_q.group == PNL_GRP_CONT || s_q.left != 4'h0) ? PNL_BL_ON : PNL_BL_GAP;
				end
				PNL_BL_GAP: if (gap_end) begin
					s_d.bl   = PNL_BL_ON;
					s_d.tmr  = 32'h0;
					s_d.left = s_d.group;
				end
				default: s_d.bl = PNL_BL_GAP;
			endcase
		end
		run_lamp = s_d.fatal ? (s_d.bl == PNL_BL_ON) : s_d.running;

		// Lamps.
		s_d.lamps.ready   = s_d.diag_ok;
		s_d.lamps.run     = run_lamp;
		s_d.lamps.serial  = ser_link_active;
		s_d.lamps.net     = !addr_ok || net_link_active;
		s_d.lamps.protect = s_d.protect;
		s_d.lamps.battery = battery_low;
		s_d.lamps.fault   = net_comm_error;

		// Address phase; read data is taken from the updated state so a write is seen at once.
		s_d.ready = 1'b1;
		// Transfer size is not decoded: only whole words are mapped and no wait state is inserted.
		take      = hsel && htrans[1] && hready;
		if (take) begin
			s_d.wr_pend = hwrite;
			s_d.wr_ofs  = haddr[PNL_ADDR_W-1:0];
			s_d.rdata   = hwrite ? 32'h0 : read_mux(haddr[PNL_ADDR_W-1:0], s_d, prot_sw_pos, port_sw_pos);
		end
	end

	// A low clock enable holds every bit, bus answers included.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= S_RESET;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign hreadyout     = s_q.ready;
	// Every transfer ends OKAY; unmapped offsets simply read as zero.
	assign hresp         = 1'b0;
	assign hrdata        = s_q.rdata;
	assign lamps         = s_q.lamps;
	assign port_cfg      = s_q.port_cfg;
	assign bridge_mode   = s_q.bridge;
	assign mem_protect   = s_q.protect;
	assign node_addr     = s_q.node;
	assign node_addr_bad = s_q.node_bad;

endmodule // pnl_top

// file: tb/pnl_panel_model.sv
// Behavioural operator panel: slide switches, rotary digits and link status levels.
`timescale 1ns/1ps
module pnl_panel_model (
	input  wire logic clk,
	output logic [1:0] prot_sw_pos,
	output logic [1:0] port_sw_pos,
	output logic [3:0] tens_digit_selector,
	output logic [3:0] ones_digit_selector,
	output logic       ser_link_active,
	output logic       net_link_active,
	output logic       battery_low,
	output logic       net_comm_error
);
	initial begin
		{prot_sw_pos, port_sw_pos, tens_digit_selector, ones_digit_selector} = 12'h001;
		{net_comm_error, battery_low, net_link_active, ser_link_active} = 4'h0;
	end
	// Switches move only just after an edge, so the block never samples a half-set position.
	task set_sw(input logic [1:0] p, q, input logic [3:0] t, o);
		@(posedge clk);
		{prot_sw_pos, port_sw_pos, tens_digit_selector, ones_digit_selector} <= {p, q, t, o};
	endtask
	task set_act(input logic [3:0] a);
		@(posedge clk);
		{net_comm_error, battery_low, net_link_active, ser_link_active} <= a;
	endtask
endmodule // pnl_panel_model

// file: tb/pnl_top_asserts.sv
// Concurrent checks on lamps, switch decoding and fixed port framing of the panel block.
`timescale 1ns/1ps
module pnl_top_asserts
	import pnl_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst,
	input wire logic [1:0]   prot_sw_pos,
	input wire logic [1:0]   port_sw_pos,
	input wire logic [3:0]   tens_digit_selector,
	input wire logic [3:0]   ones_digit_selector,
	input wire logic         ser_link_active,
	input wire logic         net_link_active,
	input wire logic         battery_low,
	input wire logic         net_comm_error,
	input wire pnl_lamps_t   lamps,
	input wire pnl_ser_cfg_t port_cfg,
	input wire logic         bridge_mode,
	input wire logic         mem_protect,
	input wire logic [7:0]   node_addr,
	input wire logic         node_addr_bad
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_serial_lamp: assert property (!$past(rst) |-> lamps.serial == $past(ser_link_active))
		else $error("serial lamp wrong");
	a_battery_lamp: assert property (!$past(rst) |-> lamps.battery == $past(battery_low))
		else $error("battery lamp wrong");
	a_fault_lamp: assert property (!$past(rst) |-> lamps.fault == $past(net_comm_error))
		else $error("fault lamp wrong");
	a_protect_map: assert property (!$past(rst) |->
		mem_protect == ($past(prot_sw_pos) == PNL_POS_TOP) && lamps.protect == mem_protect)
		else $error("protect decode wrong");
	a_node_sum: assert property (!$past(rst) |->
		node_addr == $past(tens_digit_selector) * PNL_TENS_WEIGHT + $past(ones_digit_selector))
		else $error("node address wrong");
	a_addr_bad: assert property (!$past(rst) |-> node_addr_bad == (node_addr == 8'h00 ||
		node_addr > PNL_NODE_ADDR_MAX || $past(tens_digit_selector) > PNL_DIGIT_MAX ||
		$past(ones_digit_selector) > PNL_DIGIT_MAX)) else $error("invalid address flag wrong");
	a_net_lamp: assert property (!$past(rst) |-> lamps.net == ($past(net_link_active) | node_addr_bad))
		else $error("net lamp wrong");
	a_ascii_fixed: assert property (!$past(rst) && $past(port_sw_pos) == PNL_POS_TOP |->
		port_cfg[7:0] == 8'h2a && bridge_mode) else $error("ascii framing wrong");
	a_rtu_fixed: assert property (!$past(rst) && $past(port_sw_pos) == PNL_POS_MID |->
		port_cfg[7:0] == 8'h6e && bridge_mode) else $error("rtu framing wrong");
	a_fixed_addr: assert property (!$past(rst) && !$past(port_sw_pos[1]) |-> port_cfg.addr == node_addr)
		else $error("fixed mode address wrong");
endmodule // pnl_top_asserts
bind pnl_top pnl_top_asserts u_chk (.*);

// file: tb/tb.sv
// Self-checking bench for the panel block: lamps, blink groups, switches and register bus.
`timescale 1ns/1ps
module tb;
	import pnl_pkg::*;
	localparam int HALF = 4;
	localparam int GAP  = 12;
	logic         clk, rst, hwrite, hreadyout, hresp, bridge_mode, mem_protect, node_addr_bad;
	logic [1:0]   htrans, prot_sw_pos, port_sw_pos;
	logic [3:0]   tens_digit_selector, ones_digit_selector;
	logic         ser_link_active, net_link_active, battery_low, net_comm_error;
	logic [31:0]  haddr, hwdata, hrdata;
	logic [7:0]   node_addr;
	pnl_lamps_t   lamps;
	pnl_ser_cfg_t port_cfg;
	int           err_total, samples_checked;
	logic [15:0]  codes [16] = '{16'h0000, 16'h080b, 16'h080c, 16'h082e, 16'h0769, 16'h072a, 16'h0730, 16'h0604,
		16'h0631, 16'h0503, 16'h052d, 16'h0402, 16'h0300, 16'h8001, 16'h8003, 16'h0731};
	logic [3:0]   grps [16] = '{4'h0, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7,
		4'h8, 4'h8, 4'h1};
	logic [19:0]  addrs [5] = '{20'h06440, 20'h16541, 20'h10000, 20'h11a14, 20'h00101};

	pnl_top #(.BLINK_HALF_CYC(HALF), .BLINK_GAP_CYC(GAP)) uut (.ce(1'b1), .hsel(1'b1), .hsize(3'h2),
		.hready(hreadyout), .*);
	pnl_panel_model pm (.*);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task end_of_test;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(hrdata, e);
		chk(hresp, 1'b0);
	endtask

	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// The window spans whole periods, so the count does not depend on where it starts.
	task t_blink(input logic [15:0] code, input int g);
		int n, w;
		logic p;
		n = 0;
		w = (g == 0) ? 18 * HALF : 2 * (2 * g * HALF + GAP);
		bus(PNL_OFS_CTRL, 1'b1, 32'h0);
		bus(PNL_OFS_CRASH, 1'b1, {16'h0, code});
		bus(PNL_OFS_CTRL, 1'b1, 32'h4);
		settle();
		p = lamps.run;
		for (int i = 0; i < w; i++) begin
			@(posedge clk);
			#1;
			if (lamps.run && !p) n++;
			p = lamps.run;
		end
		chk(n, (g == 0) ? 9 : 2 * g);
	endtask

	task t_panel;
		bus(PNL_OFS_CTRL, 1'b1, 32'h3);
		settle();
		chk(lamps[1:0], 2'h3);
		bus(PNL_OFS_CTRL, 1'b1, 32'h4);
		for (int i = 0; i < 16; i++) begin
			bus(PNL_OFS_CRASH, 1'b1, {16'h0, codes[i]});
			bus(PNL_OFS_STATUS, 1'b0, 32'h0);
			chk(hrdata[19:16], grps[i]);
		end
		t_blink(16'h0000, 0);
		t_blink(16'h072c, 3);
		t_blink(16'h8002, 8);
		bus(PNL_OFS_CTRL, 1'b1, 32'h0);
		settle();
		chk(lamps[1:0], 2'h0);
	endtask

	task t_switches;
		for (int p = 0; p < 3; p++) begin
			pm.set_sw(p[1:0], PNL_POS_BOT, 4'h1, 4'h1);
			settle();
			chk({mem_protect, lamps.protect}, (p == 0) ? 2'h3 : 2'h0);
		end
		pm.set_sw(PNL_POS_MID, PNL_POS_TOP, 4'h1, 4'h1);
		bus(PNL_OFS_SWCFG, 1'b1, 32'h0593);
		settle();
		chk({bridge_mode, port_cfg}, 17'h10b2a);
		pm.set_sw(PNL_POS_MID, PNL_POS_MID, 4'h1, 4'h1);
		settle();
		chk({bridge_mode, port_cfg}, 17'h10b6e);
		pm.set_sw(PNL_POS_MID, PNL_POS_BOT, 4'h1, 4'h1);
		bus(PNL_OFS_SWCFG, 1'b1, 32'hf793);
		settle();
		chk({bridge_mode, port_cfg}, 17'h0f793);
		bus(PNL_OFS_SWCFG, 1'b1, 32'hf893);
		bus(PNL_OFS_SWCFG, 1'b1, 32'hf7b3);
		bus(PNL_OFS_SWCFG, 1'b1, 32'h0093);
		rdchk(PNL_OFS_PORT, 32'hf793);
		bus(PNL_OFS_CTRL, 1'b1, 32'h8);
		settle();
		chk(bridge_mode, 1'b1);
		bus(8'h14, 1'b1, 32'hffffffff);
		rdchk(8'h14, 32'h0);
	endtask

	task t_address;
		for (int i = 0; i < 5; i++) begin
			pm.set_sw(PNL_POS_MID, PNL_POS_BOT, addrs[i][15:12], addrs[i][11:8]);
			settle();
			chk({node_addr_bad, lamps.net, node_addr}, {addrs[i][16], addrs[i][16], addrs[i][7:0]});
		end
		for (int i = 0; i < 4; i++) begin
			pm.set_act(4'h1 << i);
			settle();
			chk({lamps.fault, lamps.battery, lamps.net, lamps.serial}, 4'h1 << i);
		end
	endtask

	initial begin
		rst = 1'b1;
		{haddr, hwdata, htrans, hwrite} = '0;
		err_total = 0;
		samples_checked = 0;
		repeat (7) @(posedge clk);
		#1;
		chk({lamps, port_cfg, hreadyout}, {7'h0, 16'h016e, 1'b1});
		@(posedge clk);
		rst <= 1'b0;
		t_panel();
		t_switches();
		t_address();
		end_of_test();
	end

	initial begin
		#200000;
		err_total++;
		end_of_test();
	end
endmodule // tb
